//--- rtl/osc_startup_defs.svh
// constants for the oscillator start-up sequencer
`ifndef OSC_STARTUP_DEFS_SVH
`define OSC_STARTUP_DEFS_SVH
`define FREQ_CTRL_A_ADDR 8'h00
`define FREQ_CTRL_B_ADDR 8'h04
`define SEQ_STATUS_ADDR 8'h08
`define FREQ_CTRL_A_RESET 8'h33
`define FREQ_CTRL_B_RESET 8'h03
`define DIV_SEL_LSB 0
`define MODE_SEL_LSB 2
`define SYS_SEL_BIT 0
`define OSC_EN_BIT 1
`define DOUBLER_BIT 2
`define LOCK_BIT 7
`define SLOW_STAB_COUNT 8192
`define BOOT_STAB_COUNT 8192
`define SHORT_STAB_COUNT 128
`define LONG_STAB_COUNT 4096
`define PLL_MULT 250
`define PLL_LOCK_MIN 244
`define PLL_LOCK_MAX 256
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

//--- rtl/osc_startup_pkg.sv
// types for the oscillator start-up sequencer
package osc_startup_pkg;
   typedef enum logic [1:0] {MODE_RC, MODE_XTAL, MODE_PLL, MODE_EXT} hsMode_type;
   typedef enum logic [1:0] {OSC_OFF, OSC_COUNT, OSC_RUN} oscState_type;
endpackage

//--- rtl/osc_startup_sequencer.sv
// oscillator start-up and clock gating sequencer with axi4-lite registers
// Notes on behaviour
// - slow clock gated until 8192 counted
// - slow oscillator starts from power-on reset
// - stop halts slow; wake repeats full start
// - doubler bit gives 64 kHz enable
// - cpu stalls on unready selected clock
// - rc mode delivers after 128 pulses
// - reset release needs 8192 rc pulses
// - rc and pll free both pins
// - crystal mode owns both pins
// - crystal mode delivers after 4096 pulses
// - external clock on input pin only
// - pll lock within 2.5 percent of 250x
// - pll mode delivers after 4096 pulses
// - pll undivided setting halves like setting one
// - pll reference is raw slow clock
// - hold system reset until rc boot count
// - enable after mode set starts sequence
// - stop halts fast; wake repeats count
// - count 128 rc/ext, 4096 crystal/pll
// - mode change only while disabled
// - disabled oscillation forces slow select
`timescale 1ns/1ps
`default_nettype none
`include "osc_startup_defs.svh"
module osc_startup_sequencer
   import osc_startup_pkg::*;
#(
   parameter int SLOW_STAB = `SLOW_STAB_COUNT,
   parameter int BOOT_STAB = `BOOT_STAB_COUNT,
   parameter int LONG_STAB = `LONG_STAB_COUNT,
   parameter int SHORT_STAB = `SHORT_STAB_COUNT
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slowXtalIn,
   input wire logic fastOscPinIn,
   input wire logic rcOscIn,
   input wire logic pllOscIn,
   input wire logic extWake,
   input wire logic stopReq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic slowClock,
   output logic slowDoubleClock,
   output logic fastClock,
   output logic sysClockSelect,
   output logic systemReset,
   output logic cpuStall,
   output logic pllLockFlag,
   output logic stopActive,
   output logic fastOscPinOut,
   output logic fastOscPinOutEn_n,
   output logic fastPinInGpioFree,
   output logic fastPinOutGpioFree
);
   logic [1:0] rstPipe;
   logic rstSync;
   logic [4:0] sync1, sync2, sync3;
   logic [2:0] syncFill;
   logic slowEdge, slowFall, fastPinEdge, rcEdge, pllEdge, wakeSeen;
   logic [1:0] divSel, next_divSel;
   hsMode_type hsMode;
   logic hsOscEnable, lsDoublerEnable;
   logic [13:0] slowCnt, fastCnt;
   logic [8:0] pllCnt;
   oscState_type slowState, fastState;
   logic bootPhase;
   logic fastSrcEdge;
   logic [2:0] divCnt;
   logic awHeld, wHeld;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic doWrite;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSync = rstPipe[1];

   // pin synchronisers and one more stage for edges
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
         sync3 <= 5'h00;
         syncFill <= 3'h0;
      end else begin
         sync1 <= {extWake, pllOscIn, rcOscIn, fastOscPinIn, slowXtalIn};
         sync2 <= sync1;
         sync3 <= sync2;
         syncFill <= {syncFill[1:0], 1'b1};
      end
   end
   // edges masked until both compare stages hold real pin levels
   assign slowEdge = syncFill[2] & sync2[0] & ~sync3[0];
   assign slowFall = syncFill[2] & ~sync2[0] & sync3[0];
   assign fastPinEdge = syncFill[2] & sync2[1] & ~sync3[1];
   assign rcEdge = syncFill[2] & sync2[2] & ~sync3[2];
   assign pllEdge = syncFill[2] & sync2[3] & ~sync3[3];
   assign wakeSeen = sync2[4];

   function automatic logic [13:0] stabCount(input hsMode_type m, input logic boot);
      logic [13:0] c;
      c = 14'(SHORT_STAB);
      if (boot) begin
         c = 14'(BOOT_STAB);
      end else if (m == MODE_XTAL || m == MODE_PLL) begin
         c = 14'(LONG_STAB);
      end
      return c;
   endfunction

   // stop entry by software, release by external interrupt
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         stopActive <= 1'b0;
      end else if (stopActive && wakeSeen) begin
         stopActive <= 1'b0;
      end else if (stopReq) begin
         stopActive <= 1'b1;
      end
   end

   // slow oscillator runs from reset, no software step
   // stop halts slow side, restarts whole count
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         slowState <= OSC_COUNT;
         slowCnt <= 14'h0000;
      end else if (stopActive) begin
         slowState <= OSC_COUNT;
         slowCnt <= 14'h0000;
      end else begin
         case (slowState)
            OSC_COUNT: begin
               if (slowEdge) begin
                  if (slowCnt == 14'(SLOW_STAB - 1)) begin
                     slowState <= OSC_RUN;
                  end
                  slowCnt <= slowCnt + 14'h0001;
               end
            end
            OSC_RUN: begin
               slowCnt <= slowCnt;
            end
            default: begin
               slowState <= OSC_COUNT;
            end
         endcase
      end
   end

   // slow clock enables and doubled rate
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         slowClock <= 1'b0;
         slowDoubleClock <= 1'b0;
      end else begin
         slowClock <= slowState == OSC_RUN && slowEdge;
         // both edges give twice the slow rate
         slowDoubleClock <= slowState == OSC_RUN && lsDoublerEnable && (slowEdge || slowFall);
      end
   end

   always_comb begin
      case (hsMode)
         MODE_RC: fastSrcEdge = rcEdge;
         MODE_PLL: fastSrcEdge = pllEdge;
         default: fastSrcEdge = fastPinEdge;
      endcase
   end

   // fast sequencer: boot count, then per-mode count after enable
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         fastState <= OSC_COUNT;
         fastCnt <= 14'h0000;
         bootPhase <= 1'b1;
      end else if (stopActive || !hsOscEnable) begin
         // counter restarts on disable or stop
         fastState <= OSC_OFF;
         fastCnt <= 14'h0000;
      end else begin
         case (fastState)
            OSC_OFF: begin
               fastState <= OSC_COUNT;
               fastCnt <= 14'h0000;
            end
            OSC_COUNT: begin
               if (fastSrcEdge) begin
                  if (fastCnt == stabCount(hsMode, bootPhase) - 14'h0001) begin
                     fastState <= OSC_RUN;
                     bootPhase <= 1'b0;
                  end
                  fastCnt <= fastCnt + 14'h0001;
               end
            end
            OSC_RUN: begin
               fastCnt <= fastCnt;
            end
            default: begin
               fastState <= OSC_OFF;
            end
         endcase
      end
   end

   // system reset held through rc boot count
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         systemReset <= 1'b1;
      end else begin
         systemReset <= bootPhase;
      end
   end

   // fast clock divider
   always_comb begin
      next_divSel = divSel;
      // undivided request in pll mode halves
      if (hsMode == MODE_PLL && divSel == 2'h0) begin
         next_divSel = 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         divCnt <= 3'h0;
         fastClock <= 1'b0;
      end else if (fastState != OSC_RUN) begin
         divCnt <= 3'h0;
         fastClock <= 1'b0;
      end else begin
         fastClock <= fastSrcEdge && ((divCnt & ((3'h1 << next_divSel) - 3'h1)) == 3'h0);
         if (fastSrcEdge) begin
            divCnt <= divCnt + 3'h1;
         end
      end
   end

   // lock: pll pulses per slow cycle near 250
   // reference taken from the raw slow edge
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         pllCnt <= 9'h000;
         pllLockFlag <= 1'b0;
      end else if (stopActive || !hsOscEnable || hsMode != MODE_PLL) begin
         pllCnt <= 9'h000;
         pllLockFlag <= 1'b0;
      end else if (slowEdge) begin
         pllLockFlag <= pllCnt >= 9'(`PLL_LOCK_MIN) && pllCnt <= 9'(`PLL_LOCK_MAX);
         pllCnt <= 9'(pllEdge);
      end else if (pllEdge && pllCnt != 9'h1FF) begin
         pllCnt <= pllCnt + 9'h001;
      end
   end

   // pin ownership by mode
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         fastPinInGpioFree <= 1'b1;
         fastPinOutGpioFree <= 1'b1;
         fastOscPinOutEn_n <= 1'b1;
         fastOscPinOut <= 1'b0;
      end else begin
         // rc/pll free both, crystal owns both
         fastPinInGpioFree <= hsMode == MODE_RC || hsMode == MODE_PLL;
         fastPinOutGpioFree <= hsMode != MODE_XTAL;
         fastOscPinOutEn_n <= !(hsMode == MODE_XTAL && hsOscEnable && !stopActive);
         fastOscPinOut <= ~sync2[1];
      end
   end

   // stall cpu while the chosen clock is not ready
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         cpuStall <= 1'b1;
      end else begin
         cpuStall <= sysClockSelect ? fastState != OSC_RUN : slowState != OSC_RUN;
      end
   end

   // axi4-lite write path
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr == `FREQ_CTRL_A_ADDR || awAddr == `FREQ_CTRL_B_ADDR || awAddr == `SEQ_STATUS_ADDR) begin
               s_axi_bresp <= `AXI_RESP_OKAY;
            end else begin
               s_axi_bresp <= `AXI_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // control bits
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         divSel <= 2'(`FREQ_CTRL_A_RESET >> `DIV_SEL_LSB);
         hsMode <= MODE_RC;
         hsOscEnable <= 1'(`FREQ_CTRL_B_RESET >> `OSC_EN_BIT);
         sysClockSelect <= 1'(`FREQ_CTRL_B_RESET >> `SYS_SEL_BIT);
         lsDoublerEnable <= 1'(`FREQ_CTRL_B_RESET >> `DOUBLER_BIT);
      end else begin
         if (doWrite && wStrb[0] && awAddr == `FREQ_CTRL_A_ADDR) begin
            divSel <= wData[`DIV_SEL_LSB +: 2];
            if (!hsOscEnable) begin
               hsMode <= hsMode_type'(wData[`MODE_SEL_LSB +: 2]);
            end
         end
         if (doWrite && wStrb[0] && awAddr == `FREQ_CTRL_B_ADDR) begin
            hsOscEnable <= wData[`OSC_EN_BIT];
            lsDoublerEnable <= wData[`DOUBLER_BIT];
            sysClockSelect <= wData[`SYS_SEL_BIT] && wData[`OSC_EN_BIT];
         end else if (!hsOscEnable) begin
            sysClockSelect <= 1'b0;
         end
      end
   end

   // axi4-lite read path
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AXI_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr == `FREQ_CTRL_A_ADDR) begin
               s_axi_rdata[`DIV_SEL_LSB +: 2] <= divSel;
               s_axi_rdata[`MODE_SEL_LSB +: 2] <= hsMode;
            end else if (s_axi_araddr == `FREQ_CTRL_B_ADDR) begin
               s_axi_rdata[`SYS_SEL_BIT] <= sysClockSelect;
               s_axi_rdata[`OSC_EN_BIT] <= hsOscEnable;
               s_axi_rdata[`DOUBLER_BIT] <= lsDoublerEnable;
               s_axi_rdata[`LOCK_BIT] <= pllLockFlag;
            end else if (s_axi_araddr == `SEQ_STATUS_ADDR) begin
               s_axi_rdata[3:0] <= {stopActive, systemReset, fastState == OSC_RUN, slowState == OSC_RUN};
            end else begin
               s_axi_rresp <= `AXI_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   sequence slowCounted;
      slowState == OSC_COUNT && slowEdge && slowCnt == 14'(SLOW_STAB - 1) && !stopActive;
   endsequence
   chk_slow_gate: assert property (@(posedge clk) disable iff (!rstSync)
      slowClock |-> $past(slowState) == OSC_RUN) else $error("slow clock passed before count");
   chk_slow_open: assert property (@(posedge clk) disable iff (!rstSync)
      slowCounted |=> slowState == OSC_RUN) else $error("slow gate did not open");
   chk_stop_slow: assert property (@(posedge clk) disable iff (!rstSync)
      stopActive |=> slowState == OSC_COUNT && slowCnt == 14'h0000) else $error("slow not halted in stop");
   chk_doubler_off: assert property (@(posedge clk) disable iff (!rstSync)
      !$past(lsDoublerEnable) |-> !slowDoubleClock) else $error("doubled clock while disabled");
   chk_boot_reset: assert property (@(posedge clk) disable iff (!rstSync)
      bootPhase |=> systemReset) else $error("system reset released early");
   // crystal count reaches 4096 before run
   chk_xtal_count: assert property (@(posedge clk) disable iff (!rstSync)
      $rose(fastState == OSC_RUN) && hsMode == MODE_XTAL && !$past(bootPhase)
      |-> fastCnt == 14'(LONG_STAB)) else $error("crystal run at wrong count");
   // rc count of 128 after boot
   chk_rc_count: assert property (@(posedge clk) disable iff (!rstSync)
      $rose(fastState == OSC_RUN) && hsMode == MODE_RC && !$past(bootPhase)
      |-> fastCnt == 14'(SHORT_STAB)) else $error("rc run at wrong count");
   chk_force_slow: assert property (@(posedge clk) disable iff (!rstSync)
      !hsOscEnable |-> !sysClockSelect) else $error("fast select while disabled");
   chk_cnt_restart: assert property (@(posedge clk) disable iff (!rstSync)
      !hsOscEnable |=> fastCnt == 14'h0000 && fastState == OSC_OFF) else $error("counter not restarted");
   chk_mode_hold: assert property (@(posedge clk) disable iff (!rstSync)
      hsOscEnable && $past(hsOscEnable) |-> $stable(hsMode)) else $error("mode changed while enabled");
   chk_xtal_pins: assert property (@(posedge clk) disable iff (!rstSync)
      hsMode == MODE_XTAL ##1 hsMode == MODE_XTAL |-> !fastPinInGpioFree && !fastPinOutGpioFree)
      else $error("crystal pins left free");
   chk_lock_mode: assert property (@(posedge clk) disable iff (!rstSync)
      pllLockFlag |-> $past(hsMode) == MODE_PLL) else $error("lock outside pll mode");
endmodule
`default_nettype wire

//--- sim/osc_source_model.sv
// oscillator sources seen by the sequencer: slow crystal, rc, pll, fast pin
`timescale 1ns/1ps
`default_nettype none
module osc_source_model(
   input wire logic clk,
   input wire logic halt,
   output logic slowXtalIn,
   output logic rcOscIn,
   output logic pllOscIn,
   output logic fastOscPinIn
);
   int cs = 0;
   int cr = 0;
   int cp = 0;
   int cf = 0;
   always @(posedge clk) begin
      if (!halt) begin
         cs <= (cs + 1) % 1500;
         cr <= (cr + 1) % 6;
         cp <= (cp + 1) % 6;
         cf <= (cf + 1) % 10;
      end
   end
   assign slowXtalIn = cs >= 750;
   assign rcOscIn = cr >= 3;
   assign pllOscIn = cp >= 3;
   // fast pin 4 MHz, valid level
   assign fastOscPinIn = cf >= 5;
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the oscillator start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "osc_startup_defs.svh"
module tb;
   import osc_startup_pkg::*;
   localparam int SS = 4, BS = 16, LS = 32, HS = 8;
   logic clk, rst_n, extWake, stopReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, slowXtalIn, rcOscIn, pllOscIn, fastOscPinIn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rs, rd;
   logic [3:0] s_axi_wstrb, mA;
   logic [4:0] pv;
   logic [2:0] mB;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic slowClock, slowDoubleClock, fastClock, sysClockSelect, systemReset, cpuStall;
   logic pllLockFlag, stopActive, fastOscPinOut, fastOscPinOutEn_n, fastPinInGpioFree, fastPinOutGpioFree;
   int nFail = 0, cmpCount = 0, nSlow = 0, nRc = 0, nPll = 0, nFp = 0, pSlow = 0, pFast = 0, pDbl = 0;
   int r0, r1, k0;
   int nOut = 0, o0, o1;
   osc_startup_sequencer #(.SLOW_STAB(SS), .BOOT_STAB(BS), .LONG_STAB(LS), .SHORT_STAB(HS)) uut(
      .clk, .rst_n, .slowXtalIn, .fastOscPinIn, .rcOscIn, .pllOscIn, .extWake, .stopReq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slowClock,
      .slowDoubleClock, .fastClock, .sysClockSelect, .systemReset, .cpuStall, .pllLockFlag,
      .stopActive, .fastOscPinOut, .fastOscPinOutEn_n, .fastPinInGpioFree, .fastPinOutGpioFree);
   osc_source_model src(.clk, .halt(stopActive), .slowXtalIn, .rcOscIn, .pllOscIn, .fastOscPinIn);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // edge and pulse tallies
   always @(posedge clk) begin
      nSlow += int'(slowXtalIn & ~pv[0]);
      nRc += int'(rcOscIn & ~pv[1]);
      nPll += int'(pllOscIn & ~pv[2]);
      nFp += int'(fastOscPinIn & ~pv[3]);
      pSlow += int'(slowClock);
      pFast += int'(fastClock);
      pDbl += int'(slowDoubleClock);
      nOut += int'(fastOscPinOut & ~pv[4]);
      pv = {fastOscPinOut, fastOscPinIn, pllOscIn, rcOscIn, slowXtalIn};
   end
   function automatic logic [31:0] nextRnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic int srcOf(int m);
      case (m)
         0: return nRc;
         2: return nPll;
         default: return nFp;
      endcase
   endfunction
   task automatic giveVerdict();
      $display("compares %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic inRange(input int v, input int lo, input int hi);
      chk({31'd0, v >= lo && v <= hi}, 32'd1);
   endtask
   task automatic waitSig(ref logic s, input logic v);
      int t;
      t = 0;
      while (s !== v && t < 20000) begin
         @(posedge clk);
         t++;
      end
   endtask
   task automatic axWrite(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      r = nextRnd();
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {r[31:8], d};
      s_axi_wstrb <= r[3:0] | 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (a == `FREQ_CTRL_A_ADDR) mA = mB[1] ? {mA[3:2], d[1:0]} : d[3:0];
      if (a == `FREQ_CTRL_B_ADDR) mB = {d[2:1], d[0] & d[1]};
   endtask
   task automatic axRead(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      nFail++;
      giveVerdict();
   end
   initial begin
      rs = 32'd52129;
      {rst_n, extWake, stopReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {mA, mB, pv} = {4'h3, 3'h3, 5'h00};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      chk(systemReset, 1'b1);
      r0 = nRc;
      r1 = nSlow;
      waitSig(systemReset, 1'b0);
      inRange(nRc - r0, BS, BS + 3);
      axRead(`FREQ_CTRL_A_ADDR);
      chk(rd[3:0], mA);
      axRead(`FREQ_CTRL_B_ADDR);
      chk(rd[2:0], mB);
      axWrite(`FREQ_CTRL_B_ADDR, 8'h02);
      chk(rsp, `AXI_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(cpuStall, 1'b1);
      waitSig(slowClock, 1'b1);
      inRange(nSlow - r1, SS, SS + 2);
      repeat (3) @(posedge clk);
      chk(cpuStall, 1'b0);
      axWrite(`FREQ_CTRL_B_ADDR, 8'h06);
      r0 = pSlow;
      r1 = pDbl;
      repeat (3000) @(posedge clk);
      inRange(pDbl - r1, 2 * (pSlow - r0) - 1, 2 * (pSlow - r0) + 1);
      axWrite(`FREQ_CTRL_B_ADDR, 8'h01);
      axRead(`FREQ_CTRL_B_ADDR);
      chk(rd[2:0], mB);
      chk(sysClockSelect, 1'b0);
      axRead(8'h0C);
      chk(rsp, `AXI_RESP_SLVERR);
      axWrite(8'h0C, 8'h00);
      chk(rsp, `AXI_RESP_SLVERR);
      for (int m = 0; m < 4; m++) begin
         axWrite(`FREQ_CTRL_B_ADDR, 8'h00);
         axWrite(`FREQ_CTRL_A_ADDR, {4'h0, m[1:0], 2'b00});
         r0 = srcOf(m);
         axWrite(`FREQ_CTRL_B_ADDR, 8'h03);
         repeat (3) @(posedge clk);
         chk({fastPinInGpioFree, fastPinOutGpioFree}, m == 1 ? 2'b00 : m == 3 ? 2'b01 : 2'b11);
         if (m == 1) chk(fastOscPinOutEn_n, 1'b0);
         chk(cpuStall, 1'b1);
         waitSig(fastClock, 1'b1);
         inRange(srcOf(m) - r0, m % 3 ? LS : HS, (m % 3 ? LS : HS) + 4);
         r1 = pFast;
         o0 = nOut;
         o1 = nFp;
         repeat (600) @(posedge clk);
         if (m == 1) inRange(nOut - o0, nFp - o1 - 2, nFp - o1 + 2);
         if (m == 0) k0 = pFast - r1;
         if (m == 2) inRange(2 * (pFast - r1), k0 - 4, k0 + 4);
         if (m == 2) repeat (3200) @(posedge clk);
         if (m == 2) chk(pllLockFlag, 1'b1);
         if (m == 3) axWrite(`FREQ_CTRL_A_ADDR, 8'h00);
         axRead(`FREQ_CTRL_A_ADDR);
         chk(rd[3:0], mA);
      end
      axWrite(`FREQ_CTRL_B_ADDR, 8'h00);
      axWrite(`FREQ_CTRL_A_ADDR, 8'h00);
      axWrite(`FREQ_CTRL_B_ADDR, 8'h03);
      waitSig(fastClock, 1'b1);
      stopReq <= 1'b1;
      @(posedge clk);
      stopReq <= 1'b0;
      repeat (3) @(posedge clk);
      chk(stopActive, 1'b1);
      r0 = pSlow + pFast;
      repeat (2000) @(posedge clk);
      chk(pSlow + pFast - r0, 0);
      extWake <= 1'b1;
      r0 = nSlow;
      r1 = nRc;
      repeat (4) @(posedge clk);
      extWake <= 1'b0;
      waitSig(fastClock, 1'b1);
      inRange(nRc - r1, HS, HS + 4);
      chk(systemReset, 1'b0);
      waitSig(slowClock, 1'b1);
      inRange(nSlow - r0, SS, SS + 2);
      giveVerdict();
   end
endmodule
`default_nettype wire
